// ===== crs_defines.vh
`ifndef CRS_DEFINES_VH
`define CRS_DEFINES_VH
// register selector codes for the write and read ports
`define CRS_SEL_W        4
`define CRS_SEL_DATA0    4'h0
`define CRS_SEL_DATA1    4'h1
`define CRS_SEL_DATA2    4'h2
`define CRS_SEL_DATA3    4'h3
`define CRS_SEL_ADDR0    4'h4
`define CRS_SEL_ADDR1    4'h5
`define CRS_SEL_FRAME    4'h6
`define CRS_SEL_STATIC   4'h7
`define CRS_SEL_VTB      4'h8
`define CRS_SEL_PC       4'h9
`define CRS_SEL_USP      4'hA
`define CRS_SEL_ISP      4'hB
`define CRS_SEL_FLAG     4'hC
`define CRS_SEL_SP       4'hD
// width selector for data writes
`define CRS_WID_WORD     2'h0
`define CRS_WID_LOW      2'h1
`define CRS_WID_HIGH     2'h2
`define CRS_WID_LONG     2'h3
// flag register layout
`define CRS_FLAG_W       11
`define CRS_F_CARRY      0
`define CRS_F_DEBUG      1
`define CRS_F_ZERO       2
`define CRS_F_SIGN       3
`define CRS_F_BANK       4
`define CRS_F_OVFL       5
`define CRS_F_IEN        6
`define CRS_F_STK        7
`define CRS_F_RSVD       7
`define CRS_F_IPL_LO     8
`define CRS_F_IPL_HI     10
`define CRS_FLAG_RST     11'h000
`define CRS_FLAG_WMASK   11'h7FD
// widths, slot count, software vector limit and reset values
`define CRS_W16          16
`define CRS_W20          20
`define CRS_BANK_SLOTS   8
`define CRS_BSLOT_W      3
`define CRS_SWI_LIMIT    6'h20
`define CRS_RST16        16'h0000
`define CRS_RST20        20'h00000
`endif

// ===== crs_bank_mem.v
`timescale 1ns/100ps
`include "crs_defines.vh"
// two copies of the banked registers, slots 0..6 used, registered read
module crs_bank_mem (
  input  wire                       i_sys_clk,
  input  wire                       i_arst_n,
  input  wire                       i_we,
  input  wire                       i_wbank,
  input  wire [`CRS_BSLOT_W-1:0]    i_wslot,
  input  wire [`CRS_W16-1:0]        i_wdata,
  input  wire [1:0]                 i_be,
  input  wire                       i_rbank,
  input  wire [`CRS_BSLOT_W-1:0]    i_rslot,
  output reg  [`CRS_W16-1:0]        o_rdata
);
  // bank 0 in the low half, bank 1 in the high half
  reg [`CRS_W16-1:0] mem_reg [0:2*`CRS_BANK_SLOTS-1];
  integer k;
  // byte-lane write, registered read
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (k = 0; k < 2*`CRS_BANK_SLOTS; k = k + 1) begin
        mem_reg[k] <= `CRS_RST16;
      end
      o_rdata <= `CRS_RST16;
    end else begin
      if (i_we && i_be[0]) begin
        mem_reg[{i_wbank, i_wslot}][7:0] <= i_wdata[7:0];
      end
      if (i_we && i_be[1]) begin
        mem_reg[{i_wbank, i_wslot}][15:8] <= i_wdata[15:8];
      end
      o_rdata <= mem_reg[{i_rbank, i_rslot}];
    end
  end
endmodule // crs_bank_mem

// ===== crs_irq_gate.v
`timescale 1ns/100ps
`include "crs_defines.vh"
// interrupt acceptance decision, registered
module crs_irq_gate (
  input  wire                       i_sys_clk,
  input  wire                       i_arst_n,
  input  wire                       i_req,
  input  wire                       i_maskable,
  input  wire [2:0]                 i_req_lvl,
  input  wire                       i_ien,
  input  wire [2:0]                 i_ipl,
  output reg                        o_accept
);
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_accept <= 1'b0;
    end else begin
      o_accept <= i_req && (i_req_lvl > i_ipl) && (i_ien || !i_maskable);
    end
  end
endmodule // crs_irq_gate

// ===== crs_regset.v
`timescale 1ns/100ps
`include "crs_defines.vh"
// Functional notes
// - four 16-bit data registers, byte halves
// - first+third, second+fourth pair into longs
// - two 16-bit address regs, pair long
// - thirteen registers, banked set duplicated
// - frame and static base 16 bits
// - 20-bit vector table base
// - 20-bit program counter, next instruction
// - stack select picks irq or user pointer
// - stack select cleared on irq/low swi
// - flag register 11 bits wide
// - carry captures alu carry out
// - zero flag tracks zero result
// - sign flag tracks negative result
// - bank flag picks register copy
// - overflow flag tracks overflow
// - interrupt enable gates maskable requests
// - acknowledge clears interrupt enable
// - priority level three bits, 0..7
// - accept only strictly higher priority
// - debug flag bit written zero
module crs_regset (
  input  wire                       i_sys_clk,
  input  wire                       i_arst_n,
  input  wire                       i_wr_en,
  input  wire [`CRS_SEL_W-1:0]      i_wr_sel,
  input  wire [1:0]                 i_wr_wid,
  input  wire [31:0]                i_wr_data,
  input  wire [`CRS_SEL_W-1:0]      i_rd_sel,
  input  wire                       i_rd_long,
  input  wire                       i_pc_inc,
  input  wire                       i_alu_upd,
  input  wire                       i_alu_carry,
  input  wire                       i_alu_zero,
  input  wire                       i_alu_sign,
  input  wire                       i_alu_ovfl,
  input  wire                       i_irq_req,
  input  wire                       i_irq_maskable,
  input  wire [2:0]                 i_irq_lvl,
  input  wire                       i_irq_ack,
  input  wire                       i_swi_exec,
  input  wire [5:0]                 i_swi_num,
  output reg  [31:0]                o_rd_data,
  output reg  [`CRS_FLAG_W-1:0]     o_flag,
  output reg  [`CRS_W20-1:0]        o_program_counter,
  output reg  [`CRS_W20-1:0]        o_vector_table_base,
  output reg  [`CRS_W16-1:0]        o_active_sp,
  output reg  [`CRS_W16-1:0]        o_static_base,
  output wire                       o_irq_accept
);
  // unbanked registers
  reg [`CRS_W16-1:0]    static_base_reg;
  reg [`CRS_W20-1:0]    vector_table_base_reg;
  reg [`CRS_W20-1:0]    program_counter_reg;
  reg [`CRS_W16-1:0]    user_stack_pointer_reg;
  reg [`CRS_W16-1:0]    irq_stack_pointer_reg;
  reg [`CRS_FLAG_W-1:0] flag_register_reg;
  reg [`CRS_FLAG_W-1:0] flag_register_next;
  // banked memory ports (two lanes for long reads)
  wire [`CRS_W16-1:0]   bank_lo_rdata;
  wire [`CRS_W16-1:0]   bank_hi_rdata;
  reg                   bank_we;
  reg [`CRS_BSLOT_W-1:0] bank_wslot;
  reg [`CRS_W16-1:0]    bank_wdata;
  reg [1:0]             bank_be;
  reg                   bankh_we;
  reg [`CRS_BSLOT_W-1:0] bankh_wslot;
  reg [`CRS_BSLOT_W-1:0] rd_lo_slot;
  reg [`CRS_BSLOT_W-1:0] rd_hi_slot;
  reg                   rd_banked_reg;
  reg                   rd_long_reg;
  reg                   rd_upper_reg;   // word read of an upper-half register
  reg                   lane_lo_we;     // low lane write enable
  reg                   lane_hi_we;     // high lane write enable
  reg [`CRS_BSLOT_W-1:0] lane_hi_slot;  // high lane write slot
  reg [`CRS_W16-1:0]    lane_hi_wdata;  // high lane write data
  reg [1:0]             lane_hi_be;     // high lane byte enables
  reg [31:0]            rd_plain;
  reg [31:0]            rd_plain_reg;
  wire                  cur_bank;

  // slot index of a banked selector
  function [`CRS_BSLOT_W-1:0] slot_of;
    input [`CRS_SEL_W-1:0] sel;
    begin
      slot_of = sel[`CRS_BSLOT_W-1:0];
    end
  endfunction

  // long partner: first->third, second->fourth, addr0->addr1
  function [`CRS_BSLOT_W-1:0] partner_of;
    input [`CRS_SEL_W-1:0] sel;
    begin
      case (sel)
        `CRS_SEL_DATA0: partner_of = slot_of(`CRS_SEL_DATA2);
        `CRS_SEL_DATA1: partner_of = slot_of(`CRS_SEL_DATA3);
        default:        partner_of = slot_of(`CRS_SEL_ADDR1);
      endcase
    end
  endfunction

  // true for the seven banked selectors
  function is_banked;
    input [`CRS_SEL_W-1:0] sel;
    begin
      is_banked = (sel <= `CRS_SEL_FRAME);
    end
  endfunction

  // true for the upper halves of the long pairs, which live in the high lane
  function is_upper;
    input [`CRS_SEL_W-1:0] sel;
    begin
      is_upper = (sel == `CRS_SEL_DATA2) || (sel == `CRS_SEL_DATA3) ||
                 (sel == `CRS_SEL_ADDR1);
    end
  endfunction

  assign cur_bank = flag_register_reg[`CRS_F_BANK];

  // banked write lane decode
  // byte halves
  always @* begin
    bank_we     = i_wr_en && is_banked(i_wr_sel);
    bank_wslot  = slot_of(i_wr_sel);
    bank_wdata  = i_wr_data[15:0];
    bank_be     = 2'h3;
    bankh_we    = 1'b0;
    bankh_wslot = partner_of(i_wr_sel);
    case (i_wr_wid)
      `CRS_WID_LOW: begin
        bank_be = 2'h1;
      end
      `CRS_WID_HIGH: begin
        bank_be    = 2'h2;
        bank_wdata = {i_wr_data[7:0], i_wr_data[7:0]};
      end
      `CRS_WID_LONG: begin
        bankh_we = bank_we && (i_wr_sel == `CRS_SEL_DATA0 || i_wr_sel == `CRS_SEL_DATA1
                               || i_wr_sel == `CRS_SEL_ADDR0);
      end
      default: begin
        bank_be = 2'h3;
      end
    endcase
  end

  // lane steering: upper halves sit only in the high lane, all other banked
  // registers only in the low lane, so a long write fills both halves in one
  // cycle and a later word read of either half sees the same value
  // pair halves stay one register
  always @* begin
    lane_lo_we    = bank_we && !is_upper(i_wr_sel);
    lane_hi_we    = bankh_we || (bank_we && is_upper(i_wr_sel));
    lane_hi_slot  = bank_wslot;
    lane_hi_wdata = bank_wdata;
    lane_hi_be    = bank_be;
    if (bankh_we) begin
      // long write: upper word goes to the partner slot
      lane_hi_slot  = bankh_wslot;
      lane_hi_wdata = i_wr_data[31:16];
      lane_hi_be    = 2'h3;
    end
  end

  crs_bank_mem u_bank_lo (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_we      (lane_lo_we),
    .i_wbank   (cur_bank),
    .i_wslot   (bank_wslot),
    .i_wdata   (bank_wdata),
    .i_be      (bank_be),
    .i_rbank   (cur_bank),
    .i_rslot   (rd_lo_slot),
    .o_rdata   (bank_lo_rdata)
  );

  // high lane: upper halves, written alone or together with a long write
  crs_bank_mem u_bank_hi (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_we      (lane_hi_we),
    .i_wbank   (cur_bank),
    .i_wslot   (lane_hi_slot),
    .i_wdata   (lane_hi_wdata),
    .i_be      (lane_hi_be),
    .i_rbank   (cur_bank),
    .i_rslot   (rd_hi_slot),
    .o_rdata   (bank_hi_rdata)
  );

  // read slot choice: low lane reads the selector, high lane its partner on a long read, else the selector
  always @* begin
    rd_lo_slot = slot_of(i_rd_sel);
    rd_hi_slot = i_rd_long ? partner_of(i_rd_sel) : slot_of(i_rd_sel);
  end

  // trade-off: splitting the bank over two lanes leaves four of eight slots unused in the low lane
  // and five in the high lane, but gives a long read in one cycle with no second read port
  // limitation: a long read of a banked selector other than a pair's lower half returns junk

  // unbanked read mux
  always @* begin
    case (i_rd_sel)
      `CRS_SEL_STATIC: rd_plain = {16'h0000, static_base_reg};
      `CRS_SEL_VTB:    rd_plain = {12'h000, vector_table_base_reg};
      `CRS_SEL_PC:     rd_plain = {12'h000, program_counter_reg};
      `CRS_SEL_USP:    rd_plain = {16'h0000, user_stack_pointer_reg};
      `CRS_SEL_ISP:    rd_plain = {16'h0000, irq_stack_pointer_reg};
      `CRS_SEL_FLAG:   rd_plain = {21'h000000, flag_register_reg};
      `CRS_SEL_SP:     rd_plain = {16'h0000, o_active_sp};
      default:         rd_plain = 32'h00000000;
    endcase
  end

  // read pipeline lines up with the registered bank read
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_banked_reg <= 1'b0;
      rd_long_reg   <= 1'b0;
      rd_upper_reg  <= 1'b0;
      rd_plain_reg  <= 32'h00000000;
    end else begin
      rd_banked_reg <= is_banked(i_rd_sel);
      rd_long_reg   <= i_rd_long;
      rd_upper_reg  <= is_upper(i_rd_sel);
      rd_plain_reg  <= rd_plain;
    end
  end

  // read data output register, two cycles after the select
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data <= 32'h00000000;
    end else if (rd_banked_reg) begin
      if (rd_long_reg) begin
        // long: upper half from the high lane
        o_rd_data <= {bank_hi_rdata, bank_lo_rdata};
      end else if (rd_upper_reg) begin
        // word read of an upper-half register
        o_rd_data <= {16'h0000, bank_hi_rdata};
      end else begin
        o_rd_data <= {16'h0000, bank_lo_rdata};
      end
    end else begin
      o_rd_data <= rd_plain_reg;
    end
  end

  // flag next-state; hardware events take priority over software writes
  always @* begin
    flag_register_next = flag_register_reg;
    if (i_wr_en && i_wr_sel == `CRS_SEL_FLAG) begin
      flag_register_next = i_wr_data[`CRS_FLAG_W-1:0] & `CRS_FLAG_WMASK;
    end
    if (i_alu_upd) begin
      flag_register_next[`CRS_F_CARRY] = i_alu_carry;
      flag_register_next[`CRS_F_ZERO]  = i_alu_zero;
      flag_register_next[`CRS_F_SIGN]  = i_alu_sign;
      flag_register_next[`CRS_F_OVFL]  = i_alu_ovfl;
    end
    if (i_irq_ack) begin
      flag_register_next[`CRS_F_IEN] = 1'b0;
      flag_register_next[`CRS_F_STK] = 1'b0;
    end
    if (i_swi_exec && i_swi_num < `CRS_SWI_LIMIT) begin
      flag_register_next[`CRS_F_STK] = 1'b0;
    end
  end

  // unbanked registers and flags
  // eleven-bit flag store
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      static_base_reg        <= `CRS_RST16;
      vector_table_base_reg  <= `CRS_RST20;
      program_counter_reg    <= `CRS_RST20;
      user_stack_pointer_reg <= `CRS_RST16;
      irq_stack_pointer_reg  <= `CRS_RST16;
      flag_register_reg      <= `CRS_FLAG_RST;
    end else begin
      flag_register_reg <= flag_register_next;
      if (i_wr_en && i_wr_sel == `CRS_SEL_STATIC) begin
        static_base_reg <= i_wr_data[15:0];
      end
      if (i_wr_en && i_wr_sel == `CRS_SEL_VTB) begin
        vector_table_base_reg <= i_wr_data[`CRS_W20-1:0];
      end
      if (i_wr_en && i_wr_sel == `CRS_SEL_PC) begin
        program_counter_reg <= i_wr_data[`CRS_W20-1:0];
      end else if (i_pc_inc) begin
        program_counter_reg <= program_counter_reg + 20'h00001;
      end
      // sp alias writes the active pointer
      if (i_wr_en && (i_wr_sel == `CRS_SEL_USP ||
          (i_wr_sel == `CRS_SEL_SP && flag_register_reg[`CRS_F_STK]))) begin
        user_stack_pointer_reg <= i_wr_data[15:0];
      end
      if (i_wr_en && (i_wr_sel == `CRS_SEL_ISP ||
          (i_wr_sel == `CRS_SEL_SP && !flag_register_reg[`CRS_F_STK]))) begin
        irq_stack_pointer_reg <= i_wr_data[15:0];
      end
    end
  end

  // registered status outputs, one cycle behind the state
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_flag              <= `CRS_FLAG_RST;
      o_program_counter   <= `CRS_RST20;
      o_vector_table_base <= `CRS_RST20;
      o_active_sp         <= `CRS_RST16;
      o_static_base       <= `CRS_RST16;
    end else begin
      o_flag              <= flag_register_reg;
      o_program_counter   <= program_counter_reg;
      o_vector_table_base <= vector_table_base_reg;
      o_active_sp         <= flag_register_reg[`CRS_F_STK] ? user_stack_pointer_reg
                                                            : irq_stack_pointer_reg;
      o_static_base       <= static_base_reg;
    end
  end

  crs_irq_gate u_irq_gate (
    .i_sys_clk  (i_sys_clk),
    .i_arst_n   (i_arst_n),
    .i_req      (i_irq_req),
    .i_maskable (i_irq_maskable),
    .i_req_lvl  (i_irq_lvl),
    .i_ien      (flag_register_reg[`CRS_F_IEN]),
    .i_ipl      (flag_register_reg[`CRS_F_IPL_HI:`CRS_F_IPL_LO]),
    .o_accept   (o_irq_accept)
  );
endmodule // crs_regset

// ===== crs_regset_chk.sv
`timescale 1ns/100ps
`include "crs_defines.vh"
// passive watcher on the register set ports
module crs_regset_chk (
  input logic                    i_sys_clk,
  input logic                    i_arst_n,
  input logic                    i_wr_en,
  input logic [`CRS_SEL_W-1:0]   i_wr_sel,
  input logic [1:0]              i_wr_wid,
  input logic [31:0]             i_wr_data,
  input logic [`CRS_SEL_W-1:0]   i_rd_sel,
  input logic                    i_rd_long,
  input logic                    i_pc_inc,
  input logic                    i_alu_upd,
  input logic                    i_alu_carry,
  input logic                    i_alu_zero,
  input logic                    i_alu_sign,
  input logic                    i_alu_ovfl,
  input logic                    i_irq_req,
  input logic                    i_irq_maskable,
  input logic [2:0]              i_irq_lvl,
  input logic                    i_irq_ack,
  input logic                    i_swi_exec,
  input logic [5:0]              i_swi_num,
  input logic [31:0]             o_rd_data,
  input logic [`CRS_FLAG_W-1:0]  o_flag,
  input logic [`CRS_W20-1:0]     o_program_counter,
  input logic [`CRS_W20-1:0]     o_vector_table_base,
  input logic [`CRS_W16-1:0]     o_active_sp,
  input logic [`CRS_W16-1:0]     o_static_base,
  input logic                    o_irq_accept
);
  // one clock domain, so clock and reset are given once here
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  irq_gate_a: assert property (o_irq_accept == ($past(i_irq_req) &&
    ($past(i_irq_lvl) > o_flag[10:8]) && (o_flag[6] || !$past(i_irq_maskable))))
    else $error("irq accept disagrees with request and flags");
  ack_clear_a: assert property (i_irq_ack |-> ##2 (o_flag[7:6] == 2'b00))
    else $error("acknowledge left enable or stack select set");
  swi_low_a: assert property ((i_swi_exec && (i_swi_num < `CRS_SWI_LIMIT)) |-> ##2 !o_flag[7])
    else $error("low software vector left stack select set");
  alu_flags_a: assert property (i_alu_upd |-> ##2 ({o_flag[5], o_flag[3:2], o_flag[0]} ==
    $past({i_alu_ovfl, i_alu_sign, i_alu_zero, i_alu_carry}, 2)))
    else $error("alu flags not captured");
  debug_low_a: assert property (o_flag[1] == 1'b0)
    else $error("debug flag set");
  flag_write_a: assert property ((i_wr_en && i_wr_sel == `CRS_SEL_FLAG && !i_alu_upd &&
    !i_irq_ack && !i_swi_exec) |-> ##2 (o_flag == ($past(i_wr_data[10:0], 2) & `CRS_FLAG_WMASK)))
    else $error("flag write not reflected");
  pc_step_a: assert property ((i_pc_inc && !(i_wr_en && i_wr_sel == `CRS_SEL_PC)) |->
    ##2 (o_program_counter == $past(o_program_counter) + 20'h00001))
    else $error("program counter did not step by one");
  pc_load_a: assert property ((i_wr_en && i_wr_sel == `CRS_SEL_PC) |->
    ##2 (o_program_counter == $past(i_wr_data[19:0], 2))) else $error("program counter load lost");
  vtb_load_a: assert property ((i_wr_en && i_wr_sel == `CRS_SEL_VTB) |->
    ##2 (o_vector_table_base == $past(i_wr_data[19:0], 2))) else $error("table base load lost");
  sb_load_a: assert property ((i_wr_en && i_wr_sel == `CRS_SEL_STATIC) |->
    ##2 (o_static_base == $past(i_wr_data[15:0], 2))) else $error("static base load lost");

  // main scenarios reached
  cover property (i_irq_ack);
  cover property ($rose(o_irq_accept));
  cover property (i_alu_upd && i_alu_zero);
  cover property (i_wr_en && i_wr_wid == `CRS_WID_LONG && i_wr_sel == `CRS_SEL_DATA0);
endmodule // crs_regset_chk

bind crs_regset crs_regset_chk i_chk (.*);

// ===== crs_regset_tb_top.sv
`timescale 1ns/100ps
`include "crs_defines.vh"
// directed bench for the register set, driven 10 ns after each rising edge
module crs_regset_tb_top;
  logic                    i_sys_clk, i_arst_n, i_wr_en, i_rd_long, i_pc_inc;
  logic                    i_alu_upd, i_alu_carry, i_alu_zero, i_alu_sign, i_alu_ovfl;
  logic                    i_irq_req, i_irq_maskable, i_irq_ack, i_swi_exec;
  logic [`CRS_SEL_W-1:0]   i_wr_sel, i_rd_sel;
  logic [1:0]              i_wr_wid;
  logic [31:0]             i_wr_data, o_rd_data;
  logic [2:0]              i_irq_lvl;
  logic [5:0]              i_swi_num;
  logic [`CRS_FLAG_W-1:0]  o_flag;
  logic [`CRS_W20-1:0]     o_program_counter, o_vector_table_base;
  logic [`CRS_W16-1:0]     o_active_sp, o_static_base;
  logic                    o_irq_accept;
  int                      n_mismatch, compares, b, i, k;
  logic [3:0]              lsel [3] = '{4'h0, 4'h1, 4'h4};
  logic [3:0]              lhi [3] = '{4'h2, 4'h3, 4'h5};
  int                      fpos [4] = '{0, 2, 3, 5};

  crs_regset i_dut (.*);

  // free running 100 ns clock
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  // wait edges then move off the sampling edge
  task automatic step(input int n);
    repeat (n) @(posedge i_sys_clk);
    #10;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one-cycle write strobe, then let the mirrored outputs settle
  task automatic wr(input logic [3:0] sel, input logic [1:0] wid, input logic [31:0] d);
    i_wr_en = 1'b1;
    i_wr_sel = sel;
    i_wr_wid = wid;
    i_wr_data = d;
    step(1);
    i_wr_en = 1'b0;
    step(2);
  endtask

  // selector held for three edges, read data is valid two edges after the select
  task automatic rd(input logic [3:0] sel, input logic lng, input logic [31:0] exp);
    i_rd_sel = sel;
    i_rd_long = lng;
    step(3);
    chk("read data", o_rd_data, exp);
  endtask

  // alu pulse, vector order is overflow, sign, zero, carry
  task automatic alu(input logic [3:0] v);
    {i_alu_ovfl, i_alu_sign, i_alu_zero, i_alu_carry} = v;
    i_alu_upd = 1'b1;
    step(1);
    i_alu_upd = 1'b0;
    step(2);
  endtask

  task automatic summarize;
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // hang guard, far beyond the directed run
  initial begin
    #2000000;
    n_mismatch++;
    summarize;
  end

  initial begin
    {i_arst_n, i_wr_en, i_rd_long, i_pc_inc, i_alu_upd, i_alu_carry, i_alu_zero} = '0;
    {i_alu_sign, i_alu_ovfl, i_irq_req, i_irq_maskable, i_irq_ack, i_swi_exec} = '0;
    {i_wr_sel, i_rd_sel, i_wr_wid, i_wr_data, i_irq_lvl, i_swi_num} = '0;
    repeat (12) @(posedge i_sys_clk);
    #10 i_arst_n = 1'b1;
    chk("flag", o_flag, 0);
    chk("pc", o_program_counter, 0);
    // both copies of every banked slot hold their own value
    for (b = 0; b < 2; b++) begin
      wr(`CRS_SEL_FLAG, `CRS_WID_WORD, 32'(b * 16));
      for (i = 0; i < 7; i++) wr(4'(i), `CRS_WID_WORD, 32'hFFFF0000 | 32'((b + 1) * 4096 + i));
    end
    for (b = 0; b < 2; b++) begin
      wr(`CRS_SEL_FLAG, `CRS_WID_WORD, 32'(b * 16));
      for (i = 0; i < 7; i++) rd(4'(i), 1'b0, 32'((b + 1) * 4096 + i));
    end
    // byte halves of a data register
    wr(`CRS_SEL_DATA1, `CRS_WID_LOW, 32'h000000AB);
    rd(`CRS_SEL_DATA1, 1'b0, 32'h000020AB);
    wr(`CRS_SEL_DATA1, `CRS_WID_HIGH, 32'h000000CD);
    rd(`CRS_SEL_DATA1, 1'b0, 32'h0000CDAB);
    // long pairs
    for (k = 0; k < 3; k++) begin
      wr(lsel[k], `CRS_WID_LONG, 32'h87654321 + 32'(k));
      rd(lsel[k], 1'b1, 32'h87654321 + 32'(k));
      rd(lsel[k], 1'b0, 32'h00004321 + 32'(k));
      rd(lhi[k], 1'b0, 32'h00008765);
    end
    wr(`CRS_SEL_DATA3, `CRS_WID_LOW, 32'h0000005A);
    rd(`CRS_SEL_DATA1, 1'b1, 32'h875A4322);
    wr(`CRS_SEL_STATIC, `CRS_WID_WORD, 32'h1234BEEF);
    chk("static base", o_static_base, 32'h0000BEEF);
    wr(`CRS_SEL_VTB, `CRS_WID_WORD, 32'hFFFABCDE);
    chk("table base", o_vector_table_base, 32'h000ABCDE);
    // back-to-back steps, then wrap at the top of the range
    wr(`CRS_SEL_PC, `CRS_WID_WORD, 32'h00012345);
    i_pc_inc = 1'b1;
    step(3);
    i_pc_inc = 1'b0;
    step(2);
    chk("pc", o_program_counter, 32'h00012348);
    wr(`CRS_SEL_PC, `CRS_WID_WORD, 32'h000FFFFF);
    i_pc_inc = 1'b1;
    step(1);
    i_pc_inc = 1'b0;
    step(2);
    chk("pc", o_program_counter, 0);
    // stack pointer selection
    wr(`CRS_SEL_ISP, `CRS_WID_WORD, 32'h00005555);
    wr(`CRS_SEL_USP, `CRS_WID_WORD, 32'h0000AAAA);
    wr(`CRS_SEL_FLAG, `CRS_WID_WORD, 0);
    chk("active sp", o_active_sp, 32'h00005555);
    wr(`CRS_SEL_FLAG, `CRS_WID_WORD, 32'h00000080);
    chk("active sp", o_active_sp, 32'h0000AAAA);
    wr(`CRS_SEL_SP, `CRS_WID_WORD, 32'h00001357);
    chk("active sp", o_active_sp, 32'h00001357);
    rd(`CRS_SEL_USP, 1'b0, 32'h00001357);
    rd(`CRS_SEL_ISP, 1'b0, 32'h00005555);
    rd(`CRS_SEL_SP, 1'b0, 32'h00001357);
    rd(`CRS_SEL_VTB, 1'b0, 32'h000ABCDE);
    rd(`CRS_SEL_PC, 1'b0, 32'h00000000);
    rd(`CRS_SEL_STATIC, 1'b0, 32'h0000BEEF);
    // acknowledge, low and high software vectors
    for (k = 0; k < 3; k++) begin
      wr(`CRS_SEL_FLAG, `CRS_WID_WORD, 32'h000000C0);
      i_irq_ack = (k == 0);
      i_swi_exec = (k != 0);
      i_swi_num = (k == 1) ? 6'h1F : 6'h20;
      step(1);
      {i_irq_ack, i_swi_exec} = 2'b00;
      step(2);
      chk("flag", o_flag, (k == 0) ? 0 : (k == 1) ? 32'h040 : 32'h0C0);
    end
    // each alu flag alone
    for (k = 0; k < 4; k++) begin
      alu(4'h1 << k);
      chk("flag", o_flag, 32'h0C0 | (32'h1 << fpos[k]));
    end
    wr(`CRS_SEL_FLAG, `CRS_WID_WORD, 32'h000007FF);
    rd(`CRS_SEL_FLAG, 1'b0, 32'h000007FD);
    // every request level against level 3, enabled then disabled
    i_irq_req = 1'b1;
    i_irq_maskable = 1'b1;
    for (k = 0; k < 16; k++) begin
      if (k % 8 == 0) wr(`CRS_SEL_FLAG, `CRS_WID_WORD, (k == 0) ? 32'h340 : 32'h300);
      i_irq_lvl = 3'(k);
      step(2);
      chk("accept", o_irq_accept, (k < 8) && (k % 8 > 3));
    end
    i_irq_maskable = 1'b0;
    i_irq_lvl = 3'h4;
    step(2);
    chk("accept", o_irq_accept, 1);
    i_irq_lvl = 3'h3;
    step(2);
    chk("accept", o_irq_accept, 0);
    i_irq_req = 1'b0;
    // second reset in mid-run
    i_arst_n = 1'b0;
    step(2);
    chk("flag", o_flag, 0);
    chk("read data", o_rd_data, 0);
    i_arst_n = 1'b1;
    step(2);
    chk("static base", o_static_base, 0);
    chk("active sp", o_active_sp, 0);
    rd(`CRS_SEL_DATA0, 1'b1, 32'h00000000);
    summarize;
  end
endmodule // crs_regset_tb_top
